// file: src/crc_snoop_defines.svh
// Register offsets, field positions, reset values and timing counts of the CRC block
`ifndef CRC_SNOOP_DEFINES_SVH
`define CRC_SNOOP_DEFINES_SVH
`define ADDR_SNOOP_LOW 10'h3B4
`define ADDR_SNOOP_HIGH 10'h3B5
`define ADDR_CRC_MODE 10'h3B6
`define ADDR_RESULT_LOW 10'h3BC
`define ADDR_RESULT_HIGH 10'h3BD
`define ADDR_CRC_INPUT 10'h3BE
`define SNOOP_RANGE_LOW 10'h020
`define SNOOP_RANGE_HIGH 10'h3FF
`define BIT_MODE_POLY 0
`define BIT_MODE_LSB 7
`define BIT_SNOOP_READ 6
`define BIT_SNOOP_WRITE 7
`define CCITT_POLY 16'h1021
`define CRC16_POLY 16'h8005
`define RESET_RESULT 16'h0000
`define RESET_BYTE 8'h00
`define UPDATE_CYCLES 2
`endif

// file: src/crc_snoop_pkg.sv
// Types shared by the CRC block
package crc_snoop_pkg;
	typedef enum logic [1:0] {
		ENGINE_IDLE = 2'b00,
		ENGINE_FOLD = 2'b01,
		ENGINE_STORE = 2'b10
	} engine_state_t;
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} reg_req_t;
	typedef struct packed {
		logic write;
		logic read;
		logic [9:0] addr;
		logic [15:0] data;
	} snoop_bus_t;
endpackage : crc_snoop_pkg

// file: src/byte_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Handshakes
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = store[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next pointers and fill count
	always_comb begin
		next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Register pointers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end
endmodule : byte_fifo

// file: src/crc_snoop.sv
// Byte-serial 16-bit CRC engine with register port and bus snoop
// Contract
// - 16-bit CRC with CCITT or CRC-16 polynomial selected.
// - Each byte written to input register folds into the result register; one meeting a full queue, a snoop hit or (in its fold cycle) a seed write is lost.
// - One byte update completes within two clock cycles.
// - Byte plus sixteen zeros, added to remainder, divided by polynomial.
// - In LSB-first mode the result reads bit-reversed.
// - Snoop target may be any address 020h to 3FFh.
// - Write-snoop enable (bit 15) copies written data and updates CRC; a hit that finds the queue full is dropped.
// - Read-snoop enable (bit 14) copies read data and updates CRC; a hit that finds the queue full is dropped.
// - Word access to target feeds only the lower byte.
`timescale 1ns/10ps
`include "crc_snoop_defines.svh"
module crc_snoop #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire crc_snoop_pkg::reg_req_t req,
	output logic [7:0] rdata,
	// Observed peripheral bus transfers
	input wire crc_snoop_pkg::snoop_bus_t snoop,
	// Feed back-pressure
	output logic feed_ready,
	// Engine state
	output logic busy
);
	logic [15:0] result, next_result;
	logic [7:0] in_byte, next_in_byte;
	logic [15:0] snoop_addr, next_snoop_addr;
	logic [7:0] mode, next_mode;
	logic [7:0] rdata_q, next_rdata;
	logic [7:0] work_byte, next_work_byte;
	crc_snoop_pkg::engine_state_t state, next_state;
	logic feed_valid, feed_fire, q_valid, q_ready;
	logic [7:0] feed_byte, q_byte;
	logic sw_feed, snoop_hit, seed_write;
	logic [15:0] rev_result, shown_result;
	logic take;
	logic [4:0] pending, next_pending;

	// Bit-reverse of a 16-bit value
	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15-i];
		end
		return r;
	endfunction : rev16

	// Bit-reverse of a byte
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction : rev8

	// Modulo-2 division of remainder plus byte shifted by sixteen
	function automatic logic [15:0] fold(input logic [15:0] rem, input logic [7:0] b,
		input logic [15:0] poly);
		logic [15:0] c;
		c = rem ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ poly) : (c << 1);
		end
		return c;
	endfunction : fold

	// Snoop hit and software feed decode
	always_comb begin
		snoop_hit = (snoop.addr == snoop_addr[9:0]) && (snoop.addr >= `SNOOP_RANGE_LOW)
			&& ((snoop.write && snoop_addr[8 + `BIT_SNOOP_WRITE])
			|| (snoop.read && snoop_addr[8 + `BIT_SNOOP_READ]));
		sw_feed = req.write && (req.addr == `ADDR_CRC_INPUT);
		feed_valid = snoop_hit || sw_feed;
		feed_byte = snoop_hit ? snoop.data[7:0] : req.wdata;
		seed_write = req.write && ((req.addr == `ADDR_RESULT_LOW) || (req.addr == `ADDR_RESULT_HIGH));
	end
	assign feed_fire = feed_valid && feed_ready;

	// Byte queue between feeders and engine
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(feed_valid),
		.in_ready(feed_ready),
		.in_data(feed_byte),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_byte)
	);

	assign q_ready = (state == crc_snoop_pkg::ENGINE_IDLE) && !seed_write;
	assign busy = (state != crc_snoop_pkg::ENGINE_IDLE) || q_valid;

	// Result as software sees it; a seed byte lands in the shown half its address names, the other shown half kept
	assign rev_result = rev16(result);
	assign shown_result = mode[`BIT_MODE_LSB] ? rev_result : result;
	// Engine takes the head of the queue
	assign take = (state == crc_snoop_pkg::ENGINE_IDLE) && q_valid && q_ready;

	// Engine and register next values
	always_comb begin
		next_state = state;
		next_result = result;
		next_work_byte = work_byte;
		next_in_byte = feed_fire ? feed_byte : in_byte;
		next_snoop_addr = snoop_addr;
		next_mode = mode;
		case (state)
			crc_snoop_pkg::ENGINE_IDLE: begin
				if (q_valid && q_ready) begin
					next_work_byte = mode[`BIT_MODE_LSB] ? rev8(q_byte) : q_byte;
					next_state = crc_snoop_pkg::ENGINE_FOLD;
				end
			end
			crc_snoop_pkg::ENGINE_FOLD: begin
				next_result = fold(result, work_byte,
					mode[`BIT_MODE_POLY] ? `CRC16_POLY : `CCITT_POLY);
				next_state = crc_snoop_pkg::ENGINE_STORE;
			end
			crc_snoop_pkg::ENGINE_STORE: begin
				next_state = crc_snoop_pkg::ENGINE_IDLE;
			end
			default: begin
				next_state = crc_snoop_pkg::ENGINE_IDLE;
			end
		endcase
		// Register writes; a software seed is stored in the division's own bit order
		if (req.write) begin
			case (req.addr)
				`ADDR_SNOOP_LOW: next_snoop_addr[7:0] = req.wdata;
				`ADDR_SNOOP_HIGH: next_snoop_addr[15:8] = {req.wdata[7:6], 4'h0, req.wdata[1:0]};
				`ADDR_CRC_MODE: next_mode = {req.wdata[7], 6'h00, req.wdata[0]};
				`ADDR_RESULT_LOW: next_result = mode[`BIT_MODE_LSB]
					? rev16({rev_result[15:8], req.wdata}) : {result[15:8], req.wdata};
				`ADDR_RESULT_HIGH: next_result = mode[`BIT_MODE_LSB]
					? rev16({req.wdata, rev_result[7:0]}) : {req.wdata, result[7:0]};
				default: begin
				end
			endcase
		end
	end

	// Read data, one cycle after the strobe
	always_comb begin
		logic [15:0] shown;
		shown = mode[`BIT_MODE_LSB] ? rev16(result) : result;
		next_rdata = 8'h00;
		if (req.read) begin
			case (req.addr)
				`ADDR_SNOOP_LOW: next_rdata = snoop_addr[7:0];
				`ADDR_SNOOP_HIGH: next_rdata = snoop_addr[15:8];
				`ADDR_CRC_MODE: next_rdata = mode;
				`ADDR_RESULT_LOW: next_rdata = shown[7:0];
				`ADDR_RESULT_HIGH: next_rdata = shown[15:8];
				`ADDR_CRC_INPUT: next_rdata = in_byte;
				default: next_rdata = 8'h00;
			endcase
		end
	end
	assign rdata = rdata_q;

	// Register all state except the pending count
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= crc_snoop_pkg::ENGINE_IDLE;
			result <= `RESET_RESULT;
			work_byte <= `RESET_BYTE;
			in_byte <= `RESET_BYTE;
			snoop_addr <= 16'h0000;
			mode <= 8'h00;
			rdata_q <= 8'h00;
		end else begin
			state <= next_state;
			result <= next_result;
			work_byte <= next_work_byte;
			in_byte <= next_in_byte;
			snoop_addr <= next_snoop_addr;
			mode <= next_mode;
			rdata_q <= next_rdata;
		end
	end

	// Checks
	sequence s_take;
		state == crc_snoop_pkg::ENGINE_IDLE && q_valid && q_ready;
	endsequence
	sequence s_done;
		##1 state == crc_snoop_pkg::ENGINE_FOLD ##1 state == crc_snoop_pkg::ENGINE_STORE;
	endsequence
	a_update_two_cycles: assert property (@(posedge ref_clk) disable iff (reset)
		s_take |-> s_done) else $error("byte update not finished in two cycles");
	a_fold_value: assert property (@(posedge ref_clk) disable iff (reset)
		state == crc_snoop_pkg::ENGINE_FOLD && !seed_write |=> result == fold($past(result), $past(work_byte),
		$past(mode[`BIT_MODE_POLY]) ? `CRC16_POLY : `CCITT_POLY)) else $error("fold result wrong");
	a_sw_feed_queued: assert property (@(posedge ref_clk) disable iff (reset)
		sw_feed && feed_ready |-> feed_valid && feed_byte == req.wdata) else $error("input write not queued");
	a_write_snoop: assert property (@(posedge ref_clk) disable iff (reset)
		snoop.write && snoop_addr[15] && snoop.addr == snoop_addr[9:0] && snoop.addr >= `SNOOP_RANGE_LOW
		&& feed_ready |=> in_byte == $past(snoop.data[7:0])) else $error("write snoop missed");
	a_read_snoop: assert property (@(posedge ref_clk) disable iff (reset)
		snoop.read && snoop_addr[14] && snoop.addr == snoop_addr[9:0] && snoop.addr >= `SNOOP_RANGE_LOW
		|-> snoop_hit) else $error("read snoop missed");
	a_low_byte_only: assert property (@(posedge ref_clk) disable iff (reset)
		snoop_hit |-> feed_byte == snoop.data[7:0]) else $error("snoop fed upper byte");
	a_no_stray_hit: assert property (@(posedge ref_clk) disable iff (reset)
		snoop.addr != snoop_addr[9:0] |-> !snoop_hit) else $error("snoop hit on other address");
	a_lsb_readback: assert property (@(posedge ref_clk) disable iff (reset)
		req.read && req.addr == `ADDR_RESULT_LOW && mode[`BIT_MODE_LSB] && !req.write
		|=> rdata == $past(rev_result[7:0])) else $error("lsb readback not reversed");
	a_poly_select: assert property (@(posedge ref_clk) disable iff (reset)
		state == crc_snoop_pkg::ENGINE_FOLD && work_byte == 8'h80 && result == 16'h0000
		&& mode[`BIT_MODE_POLY] && !seed_write |=> result == 16'h8303) else $error("crc16 value wrong");

	// Bytes accepted but not yet taken, to catch a lost or repeated byte
	always_comb begin
		next_pending = pending + {4'h0, feed_fire} - {4'h0, take};
	end

	// Register the pending count
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pending <= 5'h00;
		end else begin
			pending <= next_pending;
		end
	end

	// Seed write steps
	sequence s_seed_low;
		req.write && req.addr == `ADDR_RESULT_LOW;
	endsequence
	sequence s_seed_high;
		req.write && req.addr == `ADDR_RESULT_HIGH;
	endsequence
	a_seed_low_lands: assert property (@(posedge ref_clk) disable iff (reset)
		s_seed_low |=> shown_result[7:0] == $past(req.wdata)) else $error("seed low byte not stored");
	a_seed_high_lands: assert property (@(posedge ref_clk) disable iff (reset)
		s_seed_high |=> shown_result[15:8] == $past(req.wdata)) else $error("seed high byte not stored");

	// Engine stepping and byte order into the division
	a_store_to_idle: assert property (@(posedge ref_clk) disable iff (reset)
		state == crc_snoop_pkg::ENGINE_STORE |=> state == crc_snoop_pkg::ENGINE_IDLE)
		else $error("engine stuck in store");
	a_lsb_byte_in: assert property (@(posedge ref_clk) disable iff (reset)
		take && mode[`BIT_MODE_LSB] |=> work_byte == rev8($past(q_byte)))
		else $error("lsb byte not reversed");
	a_msb_byte_in: assert property (@(posedge ref_clk) disable iff (reset)
		take && !mode[`BIT_MODE_LSB] |=> work_byte == $past(q_byte))
		else $error("msb byte altered");
	a_result_hold: assert property (@(posedge ref_clk) disable iff (reset)
		state != crc_snoop_pkg::ENGINE_FOLD && !seed_write |=> result == $past(result))
		else $error("result changed without a byte");

	// Worked values of both generators
	a_ccitt_value: assert property (@(posedge ref_clk) disable iff (reset)
		state == crc_snoop_pkg::ENGINE_FOLD && work_byte == 8'h80 && result == 16'h0000
		&& !mode[`BIT_MODE_POLY] && !seed_write |=> result == 16'h9188) else $error("ccitt value wrong");
	a_ccitt_next: assert property (@(posedge ref_clk) disable iff (reset)
		state == crc_snoop_pkg::ENGINE_FOLD && work_byte == 8'hC4 && result == 16'h9188
		&& !mode[`BIT_MODE_POLY] && !seed_write |=> result == 16'h8250) else $error("ccitt second byte wrong");
	a_crc16_next: assert property (@(posedge ref_clk) disable iff (reset)
		state == crc_snoop_pkg::ENGINE_FOLD && work_byte == 8'hC4 && result == 16'h8303
		&& mode[`BIT_MODE_POLY] && !seed_write |=> result == 16'h0292) else $error("crc16 second byte wrong");

	// Snoop decode, input register and queue
	a_input_hold: assert property (@(posedge ref_clk) disable iff (reset)
		!feed_fire |=> in_byte == $past(in_byte))
		else $error("input register changed without a feed");
	a_sw_input_byte: assert property (@(posedge ref_clk) disable iff (reset)
		sw_feed && !snoop_hit && feed_ready |=> in_byte == $past(req.wdata))
		else $error("input write not stored");
	a_read_snoop_byte: assert property (@(posedge ref_clk) disable iff (reset)
		snoop_hit && snoop.read && feed_ready |=> in_byte == $past(snoop.data[7:0]))
		else $error("read snoop byte not stored");
	a_range_floor: assert property (@(posedge ref_clk) disable iff (reset)
		snoop.addr < `SNOOP_RANGE_LOW |-> !snoop_hit)
		else $error("snoop hit below range");
	a_snoop_off: assert property (@(posedge ref_clk) disable iff (reset)
		!snoop_addr[15] && !snoop_addr[14] |-> !snoop_hit)
		else $error("snoop hit while disabled");
	a_queue_bound: assert property (@(posedge ref_clk) disable iff (reset)
		pending <= 5'(FIFO_DEPTH)) else $error("byte queue overfilled");
	a_queue_matches: assert property (@(posedge ref_clk) disable iff (reset)
		(pending != 5'h00) == q_valid) else $error("queue lost or repeated a byte");
endmodule : crc_snoop

// file: testbench/snoop_agent.sv
// Far-side bus agent issuing observed peripheral transfers
`timescale 1ns/10ps
module snoop_agent (
	// Clock
	input wire logic ref_clk,
	// Observed transfer
	output crc_snoop_pkg::snoop_bus_t bus
);
	initial bus = '0;
	// One word transfer; gap zero keeps the next one back to back
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [15:0] d, input int gap);
		bus <= '{write: wr, read: !wr, addr: a, data: d};
		@(posedge ref_clk);
		if (gap > 0) begin
			bus <= '{write: 1'b0, read: 1'b0, addr: ~a, data: ~d};
			repeat (gap) @(posedge ref_clk);
		end
	endtask : xfer
endmodule : snoop_agent

// file: testbench/crc_snoop_tb.sv
// Self-checking bench for the CRC block with bus snoop
`timescale 1ns/10ps
`include "crc_snoop_defines.svh"
module crc_snoop_tb;
	logic ref_clk, reset, feed_ready, busy, sw, sr, fe;
	logic [7:0] rdata, q, mode, exp_in, fb;
	logic [15:0] exp, r, sv;
	logic [9:0] tgt, t;
	int bad_count, compares, drops, seed;
	logic [9:0] regs [7] = '{10'h3B4, 10'h3B5, 10'h3B6, 10'h3B7, 10'h3BC, 10'h3BD, 10'h3BE};
	logic [7:0] modes [4] = '{8'h00, 8'h01, 8'h80, 8'h81};
	logic [9:0] tgts [4] = '{10'h000, 10'h020, 10'h3FF, 10'h01F};
	crc_snoop_pkg::reg_req_t req;
	crc_snoop_pkg::snoop_bus_t snoop;
	crc_snoop dut (.ref_clk(ref_clk), .reset(reset), .req(req), .rdata(rdata), .snoop(snoop),
		.feed_ready(feed_ready), .busy(busy));
	snoop_agent far (.ref_clk(ref_clk), .bus(snoop));
	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [15:0] rev16(input logic [15:0] x);
		for (int i = 0; i < 16; i++) rev16[i] = x[15-i];
	endfunction : rev16
	// Software-visible result after folding one byte
	function automatic logic [15:0] vfold(input logic [15:0] v, input logic [7:0] b, input logic [7:0] m);
		logic [15:0] c;
		logic [15:0] p;
		p = m[`BIT_MODE_POLY] ? `CRC16_POLY : `CCITT_POLY;
		c = m[`BIT_MODE_LSB] ? rev16(v) ^ (rev16({8'h00, b}) & 16'hFF00) : v ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ p : {c[14:0], 1'b0};
		return m[`BIT_MODE_LSB] ? rev16(c) : c;
	endfunction : vfold
	// Reference model fed from the observed inputs
	always @(posedge ref_clk) begin
		fe = req.write && req.addr == `ADDR_CRC_INPUT || snoop.addr == tgt && tgt >= `SNOOP_RANGE_LOW
			&& (snoop.write && sw || snoop.read && sr);
		fb = (req.write && req.addr == `ADDR_CRC_INPUT) ? req.wdata : snoop.data[7:0];
		if (reset) begin
			exp = 16'h0000;
			tgt = 10'h000;
			sw = 1'b0;
			sr = 1'b0;
			mode = 8'h00;
			exp_in = 8'h00;
		end else begin
			if (req.write) case (req.addr)
				`ADDR_SNOOP_LOW: tgt[7:0] = req.wdata;
				`ADDR_SNOOP_HIGH: {sw, sr, tgt[9:8]} = {req.wdata[7:6], req.wdata[1:0]};
				`ADDR_CRC_MODE: mode = req.wdata;
				`ADDR_RESULT_LOW: exp[7:0] = req.wdata;
				`ADDR_RESULT_HIGH: exp[15:8] = req.wdata;
				default: ;
			endcase
			if (fe && !feed_ready) drops++;
			else if (fe) begin
				exp = vfold(exp, fb, mode);
				exp_in = fb;
			end
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		compares++;
		if (got !== want) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, write: w, read: !w};
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, write: 1'b0, read: 1'b0};
		// Read data stand in this quiet cycle; take them at its closing edge
		@(posedge ref_clk);
		q = rdata;
	endtask : bus
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [9:0] a);
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic rd16();
		rd(`ADDR_RESULT_LOW);
		r[7:0] = q;
		rd(`ADDR_RESULT_HIGH);
		r[15:8] = q;
	endtask : rd16
	task automatic seed16(input logic [15:0] v);
		sv = v;
		wr(`ADDR_RESULT_LOW, v[7:0]);
		wr(`ADDR_RESULT_HIGH, v[15:8]);
	endtask : seed16
	task automatic idle();
		for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge ref_clk);
		chk({15'h0000, busy}, 16'h0000);
	endtask : idle
	// Two bytes from zero; the first result is read two cycles on
	task automatic example(input logic [7:0] m, b0, b1, input logic [15:0] e0, e1);
		wr(`ADDR_CRC_MODE, m);
		seed16(16'h0000);
		wr(`ADDR_CRC_INPUT, b0);
		@(posedge ref_clk);
		rd16();
		chk(r, e0);
		wr(`ADDR_CRC_INPUT, b1);
		idle();
		rd16();
		chk(r, e1);
	endtask : example
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		seed = 32'h5F1617D4;
		req = '0;
		reset = 1'b1;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		wr(10'h3B7, 8'hA5);
		foreach (regs[i]) begin
			rd(regs[i]);
			chk({8'h00, q}, 16'h0000);
		end
		example(8'h80, 8'h01, 8'h23, 16'h1189, 16'h0A41);
		example(8'h01, 8'h80, 8'hC4, 16'h8303, 16'h0292);
		foreach (modes[i]) begin
			wr(`ADDR_CRC_MODE, modes[i]);
			rd(`ADDR_CRC_MODE);
			chk({8'h00, q}, {8'h00, modes[i]});
			seed16(16'($random(seed)));
			rd16();
			chk(r, sv);
			repeat (6) wr(`ADDR_CRC_INPUT, 8'($random(seed)));
			idle();
			rd16();
			chk(r, exp);
			rd(`ADDR_CRC_INPUT);
			chk({8'h00, q}, {8'h00, exp_in});
		end
		foreach (tgts[i]) for (int d = 0; d < 2; d++) begin
			t = (tgts[i] == 10'h000) ? 10'h020 + 10'($random(seed) & 32'h1FF) : tgts[i];
			wr(`ADDR_SNOOP_LOW, t[7:0]);
			wr(`ADDR_SNOOP_HIGH, {6'h00, t[9:8]});
			wr(`ADDR_SNOOP_HIGH, {d[0], !d[0], 4'h0, t[9:8]});
			rd(`ADDR_SNOOP_HIGH);
			chk({8'h00, q}, {8'h00, d[0], !d[0], 4'h0, t[9:8]});
			rd(`ADDR_SNOOP_LOW);
			chk({8'h00, q}, {8'h00, t[7:0]});
			seed16(16'($random(seed)));
			for (int k = 0; k < 6; k++)
				far.xfer(1'($random(seed)), ($random(seed) & 1) ? t : t ^ 10'h001, 16'($random(seed)), (k == 5) ? 1 : 0);
			idle();
			rd16();
			chk(r, exp);
		end
		wr(`ADDR_SNOOP_HIGH, 8'h81);
		repeat (16) far.xfer(1'b1, 10'h100 | tgt, 16'($random(seed)), 0);
		far.xfer(1'b1, tgt, 16'($random(seed)), 1);
		chk({15'h0000, drops > 0}, 16'h0001);
		idle();
		rd16();
		chk(r, exp);
		wrap_up();
	end
endmodule : crc_snoop_tb
